// [core/remap_regs.sv]
/*
 * Payload-width selection and I2C alias remap registers of the serializer.
 * Assumes the local I2C slave front-end, the back-channel receiver and the lock detector
 * all run on mclk, so their signals are read without synchronisers.
 */
`timescale 1ns/1ps
module remap_regs
    import remap_regs_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire reg_req_t   regReq,
    output logic [7:0]      regRdData,
    input  wire logic       rxLock,
    input  wire logic       bcModeValid,
    input  wire logic       bcWide,
    input  wire logic       bcNarrow,
    input  wire logic       learnedValid,
    input  wire logic [6:0] learnedAddr,
    input  wire i2c_addr_t  i2cIn,
    output addr_fwd_t       fwdOut,
    output logic            payloadWide,
    output logic            payloadNarrow
);

    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    logic [1:0] modeRsvd;
    logic       modeOverride;
    logic       wideSelect;
    logic       narrowSelect;
    logic       widthCurrent;
    logic       bcWideHeld;
    logic       bcNarrowHeld;
    logic [6:0] farBridgeTargetAddress;
    logic       lockFarBridgeAddress;
    logic [6:0] farBridgeLocalAlias;
    logic       aliasRsvd;
    logic [6:0] remoteTargetPhysicalAddress;
    logic       targetRsvd;
    logic [6:0] remoteTargetLocalAlias;
    logic       targetAliasRsvd;

    logic       wrMode;
    logic       wrBridge;
    logic       wrAlias;
    logic       wrTarget;
    logic       wrTargetAlias;
    logic       next_wide;
    logic       next_narrow;
    logic [7:0] next_rdData;

    assign wrMode        = regReq.wr && (regReq.addr == OFF_PAYLOAD_MODE_SELECT);
    assign wrBridge      = regReq.wr && (regReq.addr == OFF_FAR_BRIDGE_ADDRESS);
    assign wrAlias       = regReq.wr && (regReq.addr == OFF_FAR_BRIDGE_ALIAS);
    assign wrTarget      = regReq.wr && (regReq.addr == OFF_REMOTE_TARGET_ADDRESS);
    assign wrTargetAlias = regReq.wr && (regReq.addr == OFF_REMOTE_TARGET_ALIAS);

    // ----------------------------------------------------------------
    // payload width selection
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            modeRsvd     <= 2'h0;
            modeOverride <= 1'b0;
            wideSelect   <= 1'b0;
            narrowSelect <= 1'b0;
        end else if (wrMode) begin
            modeRsvd     <= regReq.wdata[BIT_RSVD_HI:BIT_RSVD_LO];
            modeOverride <= regReq.wdata[BIT_MODE_OVERRIDE];
            wideSelect   <= regReq.wdata[BIT_WIDE_SELECT];
            narrowSelect <= regReq.wdata[BIT_NARROW_SELECT];
        end
    end

    // back-channel selection is held; losing lock makes it stale
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            widthCurrent <= 1'b0;
            bcWideHeld   <= 1'b0;
            bcNarrowHeld <= 1'b0;
        end else if (bcModeValid && rxLock) begin
            widthCurrent <= 1'b1;
            bcWideHeld   <= bcWide;
            bcNarrowHeld <= bcNarrow;
        end else if (!rxLock) begin
            widthCurrent <= 1'b0;
        end
    end

    // a both-set software pattern is not legal, so it is passed on as written
    always_comb begin
        if (modeOverride) begin
            next_wide   = wideSelect;
            next_narrow = narrowSelect;
        end else begin
            next_wide   = bcWideHeld;
            next_narrow = bcNarrowHeld;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            payloadWide   <= 1'b0;
            payloadNarrow <= 1'b0;
        end else begin
            payloadWide   <= next_wide;
            payloadNarrow <= next_narrow;
        end
    end

    // ----------------------------------------------------------------
    // far bridge address, auto-loaded after lock
    // ----------------------------------------------------------------
    // a software write in the same cycle as a learned value wins: it is the newer intent
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            farBridgeTargetAddress <= ADDR_RESET;
            lockFarBridgeAddress   <= 1'b0;
        end else if (wrBridge) begin
            farBridgeTargetAddress <= regReq.wdata[ADDR_FIELD_HI:ADDR_FIELD_LO];
            lockFarBridgeAddress   <= regReq.wdata[BIT_LOW_FLAG];
        end else if (rxLock && learnedValid && !lockFarBridgeAddress) begin
            farBridgeTargetAddress <= learnedAddr;
        end
    end

    // ----------------------------------------------------------------
    // alias and target registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            farBridgeLocalAlias <= ADDR_RESET;
            aliasRsvd           <= 1'b0;
        end else if (wrAlias) begin
            farBridgeLocalAlias <= regReq.wdata[ADDR_FIELD_HI:ADDR_FIELD_LO];
            aliasRsvd           <= regReq.wdata[BIT_LOW_FLAG];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            remoteTargetPhysicalAddress <= ADDR_RESET;
            targetRsvd                  <= 1'b0;
        end else if (wrTarget) begin
            remoteTargetPhysicalAddress <= regReq.wdata[ADDR_FIELD_HI:ADDR_FIELD_LO];
            targetRsvd                  <= regReq.wdata[BIT_LOW_FLAG];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            remoteTargetLocalAlias <= ADDR_RESET;
            targetAliasRsvd        <= 1'b0;
        end else if (wrTargetAlias) begin
            remoteTargetLocalAlias <= regReq.wdata[ADDR_FIELD_HI:ADDR_FIELD_LO];
            targetAliasRsvd        <= regReq.wdata[BIT_LOW_FLAG];
        end
    end

    // ----------------------------------------------------------------
    // register read, one cycle after the strobe
    // ----------------------------------------------------------------
    always_comb begin
        case (regReq.addr)
            OFF_PAYLOAD_MODE_SELECT:
                next_rdData = {modeRsvd, modeOverride, widthCurrent, payloadWide,
                               payloadNarrow, wideSelect, narrowSelect};
            OFF_FAR_BRIDGE_ADDRESS:
                next_rdData = {farBridgeTargetAddress, lockFarBridgeAddress};
            OFF_FAR_BRIDGE_ALIAS:
                next_rdData = {farBridgeLocalAlias, aliasRsvd};
            OFF_REMOTE_TARGET_ADDRESS:
                next_rdData = {remoteTargetPhysicalAddress, targetRsvd};
            OFF_REMOTE_TARGET_ALIAS:
                next_rdData = {remoteTargetLocalAlias, targetAliasRsvd};
            default:
                next_rdData = BYTE_ZERO;
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            regRdData <= BYTE_ZERO;
        end else if (regReq.rd) begin
            regRdData <= next_rdData;
        end
    end

    // ----------------------------------------------------------------
    // alias match and address substitution
    // ----------------------------------------------------------------
    // the bridge alias takes priority if both aliases hold the same value
    logic [6:0] inAddr;
    logic       hitBridge;
    logic       hitTarget;
    assign inAddr    = i2cIn.addrByte[ADDR_FIELD_HI:ADDR_FIELD_LO];
    assign hitBridge = (farBridgeLocalAlias != ADDR_DISABLE) && (inAddr == farBridgeLocalAlias);
    assign hitTarget = !hitBridge && (remoteTargetLocalAlias != ADDR_DISABLE)
                       && (inAddr == remoteTargetLocalAlias);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fwdOut <= '0;
        end else begin
            fwdOut.valid    <= i2cIn.valid && (hitBridge || hitTarget);
            fwdOut.toBridge <= i2cIn.valid && hitBridge
                               && (farBridgeTargetAddress != ADDR_DISABLE);
            fwdOut.toTarget <= i2cIn.valid && hitTarget
                               && (remoteTargetPhysicalAddress != ADDR_DISABLE);
            fwdOut.blocked  <= i2cIn.valid
                && ((hitBridge && (farBridgeTargetAddress == ADDR_DISABLE))
                 || (hitTarget && (remoteTargetPhysicalAddress == ADDR_DISABLE)));
            fwdOut.addrByte <= hitBridge
                ? {farBridgeTargetAddress, i2cIn.addrByte[BIT_LOW_FLAG]}
                : {remoteTargetPhysicalAddress, i2cIn.addrByte[BIT_LOW_FLAG]};
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    override_width_a: assert property (
        modeOverride |=> payloadWide == $past(wideSelect))
        else $error("override width not followed");
    backchannel_width_a: assert property (
        !modeOverride |=> payloadNarrow == $past(bcNarrowHeld))
        else $error("back-channel width not followed");
    width_current_a: assert property (
        (bcModeValid && rxLock) |=> widthCurrent)
        else $error("current flag not set");
    stale_width_a: assert property (
        (!rxLock && !bcModeValid) |=> !widthCurrent)
        else $error("current flag kept without lock");
    status_read_a: assert property (
        (regReq.rd && regReq.addr == OFF_PAYLOAD_MODE_SELECT)
        |=> regRdData[BIT_WIDE_SELECTED] == $past(payloadWide))
        else $error("wide status bit wrong");
    auto_load_a: assert property (
        (rxLock && learnedValid && !lockFarBridgeAddress && !wrBridge)
        |=> farBridgeTargetAddress == $past(learnedAddr))
        else $error("learned address not loaded");
    frozen_addr_a: assert property (
        (lockFarBridgeAddress && !wrBridge) |=> $stable(farBridgeTargetAddress))
        else $error("frozen address changed");
    bridge_block_a: assert property (
        (i2cIn.valid && hitBridge && farBridgeTargetAddress == ADDR_DISABLE)
        |=> fwdOut.blocked && !fwdOut.toBridge)
        else $error("zero bridge address not blocked");
    target_remap_a: assert property (
        (i2cIn.valid && hitTarget && remoteTargetPhysicalAddress != ADDR_DISABLE)
        |=> fwdOut.toTarget && fwdOut.addrByte[ADDR_FIELD_HI:ADDR_FIELD_LO]
            == $past(remoteTargetPhysicalAddress))
        else $error("target address not substituted");
    target_block_a: assert property (
        (i2cIn.valid && hitTarget && remoteTargetPhysicalAddress == ADDR_DISABLE)
        |=> !fwdOut.toTarget)
        else $error("zero target address not blocked");
    zero_alias_a: assert property (
        (i2cIn.valid && farBridgeLocalAlias == ADDR_DISABLE
         && remoteTargetLocalAlias == ADDR_DISABLE) |=> !fwdOut.valid)
        else $error("disabled alias matched");
    dir_bit_a: assert property (
        (i2cIn.valid && (hitBridge || hitTarget))
        |=> fwdOut.addrByte[BIT_LOW_FLAG] == $past(i2cIn.addrByte[BIT_LOW_FLAG]))
        else $error("direction bit altered");

    bridge_fwd_c: cover property (fwdOut.toBridge);
    target_fwd_c: cover property (fwdOut.toTarget);
    auto_load_c:  cover property (rxLock && learnedValid && !lockFarBridgeAddress);
    override_c:   cover property (modeOverride && payloadWide);

endmodule : remap_regs

// [pkg/remap_regs_pkg.sv]
/*
 * Shared constants and carriers for the payload-mode and address-remap register bank:
 * register offsets, field positions, reset values and the packed request and answer types.
 * Assumes an I2C register front-end on the same clock that hands over decoded accesses.
 */
package remap_regs_pkg;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_PAYLOAD_MODE_SELECT   = 8'h05;
    localparam logic [7:0] OFF_FAR_BRIDGE_ADDRESS    = 8'h06;
    localparam logic [7:0] OFF_FAR_BRIDGE_ALIAS      = 8'h07;
    localparam logic [7:0] OFF_REMOTE_TARGET_ADDRESS = 8'h08;
    localparam logic [7:0] OFF_REMOTE_TARGET_ALIAS   = 8'h09;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int BIT_RSVD_HI          = 7;
    localparam int BIT_RSVD_LO          = 6;
    localparam int BIT_MODE_OVERRIDE    = 5;
    localparam int BIT_WIDTH_CURRENT    = 4;
    localparam int BIT_WIDE_SELECTED    = 3;
    localparam int BIT_NARROW_SELECTED  = 2;
    localparam int BIT_WIDE_SELECT      = 1;
    localparam int BIT_NARROW_SELECT    = 0;
    localparam int ADDR_FIELD_HI        = 7;
    localparam int ADDR_FIELD_LO        = 1;
    localparam int BIT_LOW_FLAG         = 0;

    // ----------------------------------------------------------------
    // reset and disable values
    // ----------------------------------------------------------------
    localparam logic [6:0] ADDR_RESET   = 7'h00;
    localparam logic [6:0] ADDR_DISABLE = 7'h00;
    localparam logic [7:0] BYTE_ZERO    = 8'h00;

    // register access from the local I2C front-end, all on mclk
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

    // address byte of an incoming local I2C transaction
    typedef struct packed {
        logic       valid;
        logic [7:0] addrByte;
    } i2c_addr_t;

    // remap decision, one per incoming address byte
    typedef struct packed {
        logic       valid;
        logic       toBridge;
        logic       toTarget;
        logic       blocked;
        logic [7:0] addrByte;
    } addr_fwd_t;

endpackage : remap_regs_pkg

// [test/far_end_model.sv]
/*
 * Behavioural model of the far end: lock detector, back-channel width messages and the
 * bridge address learned over the control channel.
 * Assumes the bench calls its tasks one at a time from a single procedure on mclk.
 */
`timescale 1ns/1ps
module far_end_model (
    input  wire logic       mclk,
    output logic            rxLock,
    output logic            bcModeValid,
    output logic            bcWide,
    output logic            bcNarrow,
    output logic            learnedValid,
    output logic [6:0]      learnedAddr
);
    initial begin
        rxLock       = 1'b0;
        bcModeValid  = 1'b0;
        bcWide       = 1'b1;
        bcNarrow     = 1'b1;
        learnedValid = 1'b0;
        learnedAddr  = 7'h7f;
    end

    task automatic set_lock(input logic on);
        @(posedge mclk);
        rxLock <= on;
    endtask : set_lock

    // after the pulse the width lines show the inverse, so a late sample is caught
    task automatic send_mode(input logic wide, input logic narrow);
        @(posedge mclk);
        bcModeValid <= 1'b1;
        bcWide      <= wide;
        bcNarrow    <= narrow;
        @(posedge mclk);
        bcModeValid <= 1'b0;
        bcWide      <= ~wide;
        bcNarrow    <= ~narrow;
    endtask : send_mode

    task automatic learn(input logic [6:0] addr);
        @(posedge mclk);
        learnedValid <= 1'b1;
        learnedAddr  <= addr;
        @(posedge mclk);
        learnedValid <= 1'b0;
        learnedAddr  <= ~addr;
    endtask : learn
endmodule : far_end_model

// [test/tb.sv]
/*
 * Self-checking bench for the payload-mode and remap register bank.
 * Assumes the far-end model drives the back-channel inputs and the bench the register
 * and local address-byte ports, all on mclk.
 */
`timescale 1ns/1ps
module tb;
    import remap_regs_pkg::*;

    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic        mclk, rst, rxLock, bcModeValid, bcWide, bcNarrow, learnedValid;
    logic        payloadWide, payloadNarrow;
    logic [6:0]  learnedAddr;
    logic [7:0]  regRdData, rdVal;
    reg_req_t    regReq;
    i2c_addr_t   i2cIn;
    addr_fwd_t   fwdOut;
    int          errors, nChecks, cycles;
    localparam int TIMEOUT = 3000;

    typedef struct {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] expRd;
        logic       expWide;
        logic       expNarrow;
    } row_t;

    // bits 4:2 of the mode register read back status, never the written value
    row_t rows[9] = '{
        '{8'h05, 8'h21, 8'h25, 1'b0, 1'b1}, '{8'h05, 8'h22, 8'h2a, 1'b1, 1'b0},
        '{8'h05, 8'hde, 8'hc2, 1'b0, 1'b0}, '{8'h05, 8'h00, 8'h00, 1'b0, 1'b0},
        '{8'h06, 8'ha5, 8'ha5, 1'b0, 1'b0}, '{8'h07, 8'h33, 8'h33, 1'b0, 1'b0},
        '{8'h08, 8'h44, 8'h44, 1'b0, 1'b0}, '{8'h09, 8'h55, 8'h55, 1'b0, 1'b0},
        '{8'h0a, 8'hff, 8'h00, 1'b0, 1'b0}};

    remap_regs DUT (.mclk(mclk), .rst(rst), .regReq(regReq), .regRdData(regRdData),
        .rxLock(rxLock), .bcModeValid(bcModeValid), .bcWide(bcWide), .bcNarrow(bcNarrow),
        .learnedValid(learnedValid), .learnedAddr(learnedAddr), .i2cIn(i2cIn),
        .fwdOut(fwdOut), .payloadWide(payloadWide), .payloadNarrow(payloadNarrow));

    far_end_model FE (.mclk(mclk), .rxLock(rxLock), .bcModeValid(bcModeValid),
        .bcWide(bcWide), .bcNarrow(bcNarrow), .learnedValid(learnedValid),
        .learnedAddr(learnedAddr));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        nChecks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        regReq.wr <= 1'b0;
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string msg);
        @(posedge mclk);
        regReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        regReq.rd <= 1'b0;
        #1;
        chk(regRdData, exp, msg);
    endtask : rdchk

    task automatic outs(input logic w, input logic n, input string msg);
        chk({6'h00, payloadWide, payloadNarrow}, {6'h00, w, n}, msg);
    endtask : outs

    // flags are {valid, toBridge, toTarget, blocked}; mask picks those that are judged
    task automatic send_byte(input logic [7:0] b, input logic [3:0] expF,
                             input logic [3:0] mask, input logic [7:0] expA);
        @(posedge mclk);
        i2cIn <= '{valid: 1'b1, addrByte: b};
        @(posedge mclk);
        i2cIn <= '{valid: 1'b0, addrByte: ~b};
        #1;
        chk({4'h0, {fwdOut.valid, fwdOut.toBridge, fwdOut.toTarget, fwdOut.blocked} & mask},
            {4'h0, expF & mask}, "forward flags");
        if (expF[3] && !expF[0]) begin
            chk(fwdOut.addrByte, expA, "forward address byte");
        end
    endtask : send_byte

    task automatic wrap_up;
        $display("checks %0d errors %0d", nChecks, errors);
        if (errors == 0 && nChecks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up

    // ----------------------------------------------------------------
    // clock, timeout, sequence
    // ----------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cycles++;
        if (cycles == TIMEOUT) begin
            errors++;
            $display("Error at %0t: run did not finish in time", $time);
            wrap_up();
        end
    end

    initial begin
        errors = 0; nChecks = 0; cycles = 0;
        rst = 1'b1;
        regReq = '0;
        i2cIn = '0;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        outs(1'b0, 1'b0, "outputs after reset");
        for (int a = 5; a <= 9; a++) begin
            rdchk(8'(a), 8'h00, "reset value");
        end
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].wdata);
            rdchk(rows[i].addr, rows[i].expRd, "register readback");
            outs(rows[i].expWide, rows[i].expNarrow, "payload width");
        end
        // back-channel width: ignored without lock, then taken, then overridden
        FE.send_mode(1'b1, 1'b0);
        rdchk(8'h05, 8'h00, "mode without lock");
        FE.set_lock(1'b1);
        FE.send_mode(1'b1, 1'b0);
        rdchk(8'h05, 8'h18, "mode from back-channel");
        outs(1'b1, 1'b0, "wide from back-channel");
        wr(8'h05, 8'h21);
        rdchk(8'h05, 8'h35, "override narrow");
        outs(1'b0, 1'b1, "override narrow outputs");
        wr(8'h05, 8'h00);
        rdchk(8'h05, 8'h18, "override released");
        FE.send_mode(1'b0, 1'b1);
        rdchk(8'h05, 8'h14, "narrow from back-channel");
        // learned bridge address: frozen first, then loaded
        FE.learn(7'h3c);
        rdchk(8'h06, 8'ha5, "frozen address kept");
        wr(8'h06, 8'h00);
        FE.learn(7'h3c);
        rdchk(8'h06, 8'h78, "address loaded under lock");
        FE.set_lock(1'b0);
        rdchk(8'h05, 8'h04, "status after lock loss");
        // alias remap
        wr(8'h07, 8'h32);
        send_byte(8'h33, 4'b1100, 4'b1111, 8'h79);
        send_byte(8'h54, 4'b1010, 4'b1111, 8'h44);
        send_byte(8'h10, 4'b0000, 4'b1111, 8'h00);
        wr(8'h08, 8'h00);
        send_byte(8'h55, 4'b1001, 4'b1001, 8'h00);
        wr(8'h09, 8'h00);
        send_byte(8'h01, 4'b0000, 4'b1000, 8'h00);
        wr(8'h06, 8'h00);
        send_byte(8'h33, 4'b1001, 4'b1001, 8'h00);
        wr(8'h07, 8'h00);
        send_byte(8'h01, 4'b0000, 4'b1000, 8'h00);
        // mid-run reset must clear the held back-channel width and every register again
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        outs(1'b0, 1'b0, "outputs after second reset");
        for (int a = 5; a <= 9; a++) begin
            rdchk(8'(a), 8'h00, "value after second reset");
        end
        wrap_up();
    end
endmodule : tb
